// [include/afecrb_pkg.sv]
package afecrb_pkg;
  localparam logic [3:0] ADDR_DEVCFG  = 4'h0;
  localparam logic [3:0] ADDR_DAC     = 4'h1;
  localparam logic [3:0] ADDR_UNLOCK  = 4'hF;
  localparam logic [7:0] DEVCFG_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET    = 8'h80;
  localparam logic [7:0] UNLOCK_KEY1  = 8'hFE;
  localparam logic [7:0] UNLOCK_KEY2  = 8'hED;
  localparam int         BIT_RESV     = 7;
  localparam int         BIT_PWR_HI   = 6;
  localparam int         BIT_PWR_LO   = 5;
  localparam int         BIT_FILT     = 4;
  localparam int         BIT_CMV      = 3;
  localparam int         BIT_G2_HI    = 2;
  localparam int         BIT_G2_LO    = 1;
  localparam int         BIT_G1       = 0;
  localparam int         BIT_DIR      = 7;
endpackage

// [rtl/afecrb_top.sv]
`timescale 1ns/10ps
module afecrb_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial pins
  input  wire logic       select_low,
  input  wire logic       sclk,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_n,
  // analog controls and read-back unlock status
  output logic            first_amp_stage,
  output logic            second_amp_stage,
  output logic            filter_routing,
  output logic            common_voltage_select,
  output logic [1:0]      second_stage_gain,
  output logic            first_stage_gain,
  output logic [7:0]      offset_dac_code,
  output logic            readback_open
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] s1;
  logic [2:0] s2;
  logic       sclk_d;
  always_ff @(posedge clk) begin
    s1 <= {select_low, sclk, sdio_in};
    s2 <= s1;
    sclk_d <= s2[1];
  end
  wire sel_act  = ~s2[2];
  wire sclk_s   = s2[1];
  wire sdi_s    = s2[0];
  wire sclk_up  = sclk_s & ~sclk_d;
  wire sclk_dn  = ~sclk_s & sclk_d;

  // ==========================================================
  // frame shifter: 8 instruction bits then 8 data bits
  logic [4:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] instr;
  logic [7:0] device_configuration;
  logic       unlock_half;
  logic [7:0] rdsh;
  wire        instr_done = sel_act & sclk_up & (bitcnt == 5'd7);
  wire        data_done  = sel_act & sclk_up & (bitcnt == 5'd15);
  wire [7:0]  next_shreg = {shreg[6:0], sdi_s};
  wire        is_write   = ~instr[afecrb_pkg::BIT_DIR] & (instr[6:4] == 3'b000);
  wire        is_read    = next_shreg[afecrb_pkg::BIT_DIR] & (next_shreg[6:4] == 3'b000);
  wire        wr_stb     = data_done & is_write;
  wire [3:0]  waddr      = instr[3:0];
  wire [3:0]  raddr      = next_shreg[3:0];
  // unlock register has no storage to return
  wire [7:0]  rd_val     = (raddr == afecrb_pkg::ADDR_DEVCFG) ? device_configuration :
                           (raddr == afecrb_pkg::ADDR_DAC)    ? offset_dac_code : 8'h00;
  wire        rd_go      = instr_done & is_read & readback_open;

  always_ff @(posedge clk) begin
    if (rst || !sel_act) begin
      bitcnt <= 5'd0;
      shreg  <= 8'h00;
      instr  <= 8'h00;
    end else if (sclk_up) begin
      shreg  <= next_shreg;
      bitcnt <= (bitcnt == 5'd15) ? 5'd0 : bitcnt + 5'd1;
      if (bitcnt == 5'd7) begin
        instr <= next_shreg;
      end
    end
  end

  // ==========================================================
  // registers; the reserved bit is forced low whatever the master sends
  always_ff @(posedge clk) begin
    if (rst) begin
      device_configuration <= afecrb_pkg::DEVCFG_RESET;
      offset_dac_code      <= afecrb_pkg::DAC_RESET;
    end else if (wr_stb) begin
      if (waddr == afecrb_pkg::ADDR_DEVCFG) begin
        device_configuration <= {1'b0, next_shreg[6:0]};
      end
      if (waddr == afecrb_pkg::ADDR_DAC) begin
        offset_dac_code <= next_shreg;
      end
    end
  end

  // ==========================================================
  // unlock tracking: key1 arms, key2 as the next unlock-register write opens, anything else closes
  wire ul_wr = wr_stb & (waddr == afecrb_pkg::ADDR_UNLOCK);
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_half   <= 1'b0;
      readback_open <= 1'b0;
    end else if (ul_wr) begin
      unlock_half   <= (next_shreg == afecrb_pkg::UNLOCK_KEY1);
      readback_open <= unlock_half & (next_shreg == afecrb_pkg::UNLOCK_KEY2);
    end
  end

  // ==========================================================
  // read-back driver: changes on falling sclk so the master samples on rising
  logic rd_act;
  always_ff @(posedge clk) begin
    if (rst || !sel_act) begin
      rd_act    <= 1'b0;
      rdsh      <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else if (rd_go) begin
      rd_act <= 1'b1;
      rdsh   <= rd_val;
    end else if (rd_act && sclk_dn) begin
      sdio_oe_n <= 1'b0;
      sdio_out  <= rdsh[7];
      rdsh      <= {rdsh[6:0], 1'b0};
      if (bitcnt == 5'd0) begin
        rd_act    <= 1'b0;
        sdio_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // analog control decode
  always_ff @(posedge clk) begin
    if (rst) begin
      first_amp_stage       <= 1'b0;
      second_amp_stage      <= 1'b0;
      filter_routing        <= 1'b0;
      common_voltage_select <= 1'b0;
      second_stage_gain     <= 2'b00;
      first_stage_gain      <= 1'b0;
    end else begin
      first_amp_stage       <= device_configuration[afecrb_pkg::BIT_PWR_HI];
      second_amp_stage      <= device_configuration[afecrb_pkg::BIT_PWR_LO];
      filter_routing        <= device_configuration[afecrb_pkg::BIT_FILT];
      common_voltage_select <= device_configuration[afecrb_pkg::BIT_CMV];
      second_stage_gain     <= device_configuration[afecrb_pkg::BIT_G2_HI:afecrb_pkg::BIT_G2_LO];
      first_stage_gain      <= device_configuration[afecrb_pkg::BIT_G1];
    end
  end

  // ==========================================================
  // checks
  property p_reserved_zero;
    @(posedge clk) disable iff (rst) !device_configuration[afecrb_pkg::BIT_RESV];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_unlock_only_key;
    @(posedge clk) disable iff (rst)
      $rose(readback_open) |-> $past(ul_wr) && $past(next_shreg) == afecrb_pkg::UNLOCK_KEY2;
  endproperty
  a_unlock_only_key: assert property (p_unlock_only_key) else $error("bad unlock");

  property p_lock_on_other;
    @(posedge clk) disable iff (rst)
      ul_wr && next_shreg != afecrb_pkg::UNLOCK_KEY2 |=> !readback_open;
  endproperty
  a_lock_on_other: assert property (p_lock_on_other) else $error("stayed open");

  property p_no_drive_locked;
    @(posedge clk) disable iff (rst) !readback_open && !rd_act |=> sdio_oe_n;
  endproperty
  a_no_drive_locked: assert property (p_no_drive_locked) else $error("drove while locked");

  property p_unlock_keeps;
    @(posedge clk) disable iff (rst)
      ul_wr |=> $stable(device_configuration) && $stable(offset_dac_code);
  endproperty
  a_unlock_keeps: assert property (p_unlock_keeps) else $error("unlock changed regs");

  property p_dac_write;
    @(posedge clk) disable iff (rst)
      wr_stb && waddr == afecrb_pkg::ADDR_DAC |=> offset_dac_code == $past(next_shreg);
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("dac not written");

  property p_gain_follow;
    @(posedge clk) disable iff (rst)
      1'b1 |=> first_stage_gain == $past(device_configuration[0])
           && second_stage_gain == $past(device_configuration[2:1]);
  endproperty
  a_gain_follow: assert property (p_gain_follow) else $error("gain mismatch");

  property p_power_follow;
    @(posedge clk) disable iff (rst)
      1'b1 |=> {first_amp_stage, second_amp_stage} == $past(device_configuration[6:5])
           && filter_routing == $past(device_configuration[4])
           && common_voltage_select == $past(device_configuration[3]);
  endproperty
  a_power_follow: assert property (p_power_follow) else $error("control mismatch");

  property p_reset_state;
    @(posedge clk) rst |=> !readback_open && !unlock_half && offset_dac_code == 8'h80;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  // ==========================================================
  // unlock sequence checks; a lone second key must not open read-back
  property p_key2_alone_closes;
    @(posedge clk) disable iff (rst)
      ul_wr && !unlock_half |=> !readback_open;
  endproperty
  a_key2_alone_closes: assert property (p_key2_alone_closes) else $error("opened unarmed");

  property p_pair_opens;
    @(posedge clk) disable iff (rst)
      ul_wr && unlock_half && next_shreg == afecrb_pkg::UNLOCK_KEY2 |=> readback_open;
  endproperty
  a_pair_opens: assert property (p_pair_opens) else $error("pair did not open");

  property p_key1_arms;
    @(posedge clk) disable iff (rst)
      ul_wr && next_shreg == afecrb_pkg::UNLOCK_KEY1 |=> unlock_half;
  endproperty
  a_key1_arms: assert property (p_key1_arms) else $error("first key not armed");

  property p_other_disarms;
    @(posedge clk) disable iff (rst)
      ul_wr && next_shreg != afecrb_pkg::UNLOCK_KEY1 |=> !unlock_half;
  endproperty
  a_other_disarms: assert property (p_other_disarms) else $error("stayed armed");

  property p_open_holds;
    @(posedge clk) disable iff (rst)
      !ul_wr |=> $stable(readback_open) && $stable(unlock_half);
  endproperty
  a_open_holds: assert property (p_open_holds) else $error("unlock state moved");

  // ==========================================================
  // register write checks
  property p_cfg_write;
    @(posedge clk) disable iff (rst)
      wr_stb && waddr == afecrb_pkg::ADDR_DEVCFG |=>
        device_configuration == {1'b0, $past(next_shreg[6:0])};
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cfg not written");

  property p_cfg_holds;
    @(posedge clk) disable iff (rst)
      !(wr_stb && waddr == afecrb_pkg::ADDR_DEVCFG) |=> $stable(device_configuration);
  endproperty
  a_cfg_holds: assert property (p_cfg_holds) else $error("cfg changed unasked");

  property p_dac_holds;
    @(posedge clk) disable iff (rst)
      !(wr_stb && waddr == afecrb_pkg::ADDR_DAC) |=> $stable(offset_dac_code);
  endproperty
  a_dac_holds: assert property (p_dac_holds) else $error("dac changed unasked");

  // instructions with nonzero middle bits must have no effect at all
  property p_bad_instr_ignored;
    @(posedge clk) disable iff (rst)
      data_done && instr[6:4] != 3'b000 |=> $stable(device_configuration)
        && $stable(offset_dac_code) && $stable(readback_open);
  endproperty
  a_bad_instr_ignored: assert property (p_bad_instr_ignored) else $error("bad instr acted");

  property p_read_no_write;
    @(posedge clk) disable iff (rst)
      data_done && instr[afecrb_pkg::BIT_DIR] |=> $stable(device_configuration)
        && $stable(offset_dac_code) && $stable(readback_open);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read wrote");

  // ==========================================================
  // read-back driver checks
  property p_locked_no_read;
    @(posedge clk) disable iff (rst)
      instr_done && !readback_open |=> !rd_act;
  endproperty
  a_locked_no_read: assert property (p_locked_no_read) else $error("read while locked");

  property p_readback_load;
    @(posedge clk) disable iff (rst)
      rd_go |=> rd_act && rdsh == $past(rd_val);
  endproperty
  a_readback_load: assert property (p_readback_load) else $error("bad read load");

  property p_unlock_reads_zero;
    @(posedge clk) disable iff (rst)
      rd_go && raddr == afecrb_pkg::ADDR_UNLOCK |=> rdsh == 8'h00;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero) else $error("unlock read");

  property p_release_on_deselect;
    @(posedge clk) disable iff (rst)
      !sel_act |=> sdio_oe_n && !rd_act;
  endproperty
  a_release_on_deselect: assert property (p_release_on_deselect) else $error("held pin");

  property p_drive_only_reading;
    @(posedge clk) disable iff (rst)
      !sdio_oe_n |-> rd_act;
  endproperty
  a_drive_only_reading: assert property (p_drive_only_reading) else $error("stray drive");

  // ==========================================================
  // reset checks
  property p_cfg_reset;
    @(posedge clk)
      rst |=> device_configuration == afecrb_pkg::DEVCFG_RESET && sdio_oe_n;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("bad cfg reset");

  property p_analog_reset;
    @(posedge clk)
      rst |=> !first_amp_stage && !second_amp_stage && !filter_routing
        && !common_voltage_select && second_stage_gain == 2'b00 && !first_stage_gain;
  endproperty
  a_analog_reset: assert property (p_analog_reset) else $error("bad analog reset");
endmodule

// [dv/afecrb_master.sv]
`timescale 1ns/10ps
module afecrb_master (
  // clock
  input  wire logic clk,
  // device side of the data pin
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  // serial pins
  output logic      select_low,
  output logic      sclk,
  output wire logic sdio_in
);
  logic m_en  = 1'b1;
  logic m_bit = 1'b0;
  initial select_low = 1'b1;
  initial sclk = 1'b1;
  // a released line shows the inverse of the last bit, never a held value
  assign sdio_in = m_en ? m_bit : (!sdio_oe_n ? sdio_out : !m_bit);
  task automatic xfer(input logic [7:0] ins, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {ins, d};
    select_low <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      m_en <= !(ins[7] && i < 8);
      m_bit <= w[i];
      repeat (4) @(posedge clk);
      if (i < 8) q[i] = sdio_in;
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    select_low <= 1'b1;
    m_en <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       select_low, sclk, sdio_in, sdio_out, sdio_oe_n;
  logic       p1, p2, fr, cv, g1, open, m_open, m_key, drove;
  logic [1:0] g2;
  logic [7:0] dac, m_cfg, m_dac, q;
  int         fail_count = 0;
  int         tests_run = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (sdio_oe_n === 1'b0) drove <= 1'b1;
  afecrb_top DUT (.clk(clk), .rst(rst), .select_low(select_low), .sclk(sclk),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .first_amp_stage(p1), .second_amp_stage(p2), .filter_routing(fr),
    .common_voltage_select(cv), .second_stage_gain(g2), .first_stage_gain(g1),
    .offset_dac_code(dac), .readback_open(open));
  afecrb_master m (.clk(clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .select_low(select_low), .sclk(sclk), .sdio_in(sdio_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic state();
    chk({open, p1, p2, fr, cv, g2, g1, dac}, {m_open, m_cfg[6:0], m_dac});
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic rst_seq();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    m_cfg = 8'h00;
    m_dac = 8'h80;
    m_open = 1'b0;
    m_key = 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ins, input logic [7:0] d);
    m.xfer(ins, d, q);
    if (ins == 8'h00) m_cfg = {1'b0, d[6:0]};
    if (ins == 8'h01) m_dac = d;
    if (ins == 8'h0F) begin
      m_open = m_key && d == 8'hED;
      m_key = d == 8'hFE;
    end
    state();
  endtask
  // a locked read must leave the pin released for the whole frame
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    drove = 1'b0;
    m.xfer({4'h8, a}, 8'h00, q);
    if (m_open) chk({8'h00, q}, {8'h00, e});
    else chk({15'h0000, drove}, 16'h0000);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(48));
    rst_seq();
    state();
    done("reset");
    repeat (8) wr(8'($urandom_range(1)), 8'($urandom));
    done("config writes");
    rd(4'h0, m_cfg);
    wr(8'h0F, 8'hED);
    done("locked");
    wr(8'h0F, 8'hFE);
    wr(8'h01, 8'h3C);
    wr(8'h0F, 8'hED);
    rd(4'h0, m_cfg);
    rd(4'h1, m_dac);
    rd(4'hF, 8'h00);
    done("unlock");
    wr(8'h70, 8'hFF);
    wr(8'h0F, 8'h55);
    rd(4'h1, m_dac);
    done("relock");
    wr(8'h0F, 8'hFE);
    wr(8'h0F, 8'hED);
    rst_seq();
    state();
    done("mid reset");
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule
